// file: sac_pkg.sv
// shared constants and types for the converter control link
package sac_pkg;
    localparam int RES_BITS = 18;
    localparam int CFG_BITS = 14;
    localparam int OUT_BITS = 17;
    localparam int CLK_MHZ = 125;
    localparam int CONV_NS = 1850;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
    localparam int STEP_CYC = CONV_CYC / 20;
    localparam int ACQ_NS = 650;
    localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_NS = 1000;
    localparam int DATA_CYC = (DATA_NS * CLK_MHZ) / 1000;
    localparam int QUIET_NS = 140;
    localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
    localparam int CLCLK_NS = 10;
    localparam int CLCLK_CYC = (CLCLK_NS * CLK_MHZ + 999) / 1000;
    localparam int SCK_NS = 15;
    // half period covers the three-flop pin sampler, so the device answers each fall in time
    localparam int SCK_HALF_CYC = (SCK_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam logic [17:0] UNI_MIN = 18'h0_0000;
    localparam logic [17:0] UNI_MID = 18'h2_0000;
    localparam logic [17:0] UNI_MAX = 18'h3_FFFF;
    localparam logic [17:0] BIP_MIN = 18'h2_0000;
    localparam logic [17:0] BIP_MAX = 18'h1_FFFF;
    localparam logic [17:0] BIP_FLIP = 18'h2_0000;
    // cfg field holding the input configuration (bipolar when bit 12 clear)
    localparam int CFG_BIPOLAR_POS = 12;
    localparam logic [13:0] CFG_RESET = 14'h3F_FF;
    typedef enum logic [1:0] {SAC_ACQ = 2'b00, SAC_CONV = 2'b01, SAC_DONE = 2'b11} sac_state_type;
endpackage : sac_pkg

// file: sac_link_if.sv
// link between converter device and host serial master
`timescale 1ns/10ps
`default_nettype none
interface sac_link_if;
    logic convertStrobe; // host start / select
    logic sck;           // host serial clock
    logic din;           // config data to device
    logic sdoOut;        // device data
    logic sdoOe;         // device drives data
    logic sdo;           // resolved data line
    assign sdo = sdoOe ? sdoOut : 1'b1;
    modport device (input convertStrobe, input sck, input din, output sdoOut, output sdoOe);
    modport host (output convertStrobe, output sck, output din, input sdo);
endinterface : sac_link_if
`default_nettype wire

// file: sac_device.sv
// converter device end: conversion sequencing, coding and serial port
`timescale 1ns/10ps
`default_nettype none
module sac_device
    import sac_pkg::*;
(
    input wire logic clk,                   // system clock
    input wire logic arst_n,                // async reset, low active
    sac_link_if.device link,                // serial link
    input wire logic compHigh,              // comparator: input above trial level
    input wire logic overRange,             // input above positive full scale
    input wire logic underRange,            // input below negative full scale
    output logic lowPower,                  // analog core powered down
    output logic sampling,                  // acquisition phase active
    output logic [RES_BITS-1:0] trialCode,  // trial code to the dac
    output logic [CFG_BITS-1:0] activeCfg   // configuration in force
);
    // three stage samplers for pins; a change counts when stages two and three agree
    logic [2:0] cnvSync, sckSync, dinSync;
    logic cnvLvl, sckLvl;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnvSync <= 3'h0;
            sckSync <= 3'h0;
            dinSync <= 3'h0;
        end else begin
            cnvSync <= {cnvSync[1:0], link.convertStrobe};
            sckSync <= {sckSync[1:0], link.sck};
            dinSync <= {dinSync[1:0], link.din};
        end
    end
    // filtered levels, updated only on agreement
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnvLvl <= 1'b0;
            sckLvl <= 1'b0;
        end else begin
            if (cnvSync[1] == cnvSync[2]) cnvLvl <= cnvSync[2];
            if (sckSync[1] == sckSync[2]) sckLvl <= sckSync[2];
        end
    end
    wire cnvNow = (cnvSync[1] == cnvSync[2]) ? cnvSync[2] : cnvLvl;
    wire sckNow = (sckSync[1] == sckSync[2]) ? sckSync[2] : sckLvl;
    wire cnvRise = cnvNow & ~cnvLvl;
    wire cnvFall = ~cnvNow & cnvLvl;
    wire sckRise = sckNow & ~sckLvl;
    wire sckFall = ~sckNow & sckLvl;

    // conversion state
    sac_state_type state;
    logic [4:0] bitIdx;
    logic [7:0] stepCnt;
    logic [7:0] acqCnt;
    logic [RES_BITS-1:0] result;
    logic [CFG_BITS-1:0] pendCfg;
    logic [CFG_BITS-1:0] shiftCfg;
    logic [4:0] inCnt, outCnt;
    logic [RES_BITS:0] outShift;
    logic busyMode;
    logic sdoOutR, sdoOeR;

    wire acqDone = (acqCnt == 8'(ACQ_CYC));
    wire stepEnd = (stepCnt == 8'(STEP_CYC - 1));
    wire lastBit = (bitIdx == 5'd0);
    wire isBipolar = ~activeCfg[CFG_BIPOLAR_POS];
    // next trial: keep decided bit, set the one below
    wire [RES_BITS-1:0] keepBit = compHigh ? trialCode : (trialCode & ~(UNI_MID >> (17 - bitIdx)));
    wire [RES_BITS-1:0] next_trial = lastBit ? keepBit : (keepBit | (UNI_MID >> (18 - bitIdx)));

    // output coding with clamps
    function automatic logic [RES_BITS-1:0] form_code(input logic [RES_BITS-1:0] raw,
            input logic bip, input logic ovr, input logic und);
        logic [RES_BITS-1:0] code;
        code = bip ? (raw ^ BIP_FLIP) : raw;
        if (ovr) code = bip ? BIP_MAX : UNI_MAX;
        if (und) code = bip ? BIP_MIN : UNI_MIN;
        return code;
    endfunction : form_code

    // sequencer: acquisition, 18 bit steps, then back to acquisition
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SAC_ACQ;
            bitIdx <= 5'd0;
            stepCnt <= 8'd0;
            acqCnt <= 8'd0;
            trialCode <= UNI_MIN;
            result <= UNI_MIN;
            activeCfg <= CFG_RESET;
            busyMode <= 1'b0;
        end else begin
            unique case (state)
                SAC_ACQ: begin
                    if (!acqDone) acqCnt <= acqCnt + 8'd1;
                    if (cnvRise && acqDone) begin
                        state <= SAC_CONV;
                        bitIdx <= 5'(RES_BITS - 1);
                        trialCode <= UNI_MID;
                        stepCnt <= 8'd0;
                        busyMode <= 1'b0;
                    end
                end
                SAC_CONV: begin
                    // judged at a bit boundary so the start pulse itself never counts
                    if (cnvNow && stepEnd) busyMode <= 1'b1;
                    stepCnt <= stepEnd ? 8'd0 : stepCnt + 8'd1;
                    if (stepEnd) begin
                        trialCode <= next_trial;
                        bitIdx <= bitIdx - 5'd1;
                        if (lastBit) state <= SAC_DONE;
                    end
                end
                SAC_DONE: begin
                    result <= form_code(trialCode, isBipolar, overRange, underRange);
                    activeCfg <= pendCfg;
                    acqCnt <= 8'd0;
                    state <= SAC_ACQ;
                end
                default: state <= SAC_ACQ;
            endcase
        end
    end

    // serial port: strobe low selects; config in on rises, data out on falls
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shiftCfg <= CFG_RESET;
            pendCfg <= CFG_RESET;
            inCnt <= 5'd0;
            outCnt <= 5'd0;
            outShift <= '0;
            sdoOutR <= 1'b1;
            sdoOeR <= 1'b0;
        end else if (cnvNow) begin
            // selection ends; a partial word is dropped
            inCnt <= 5'd0;
            sdoOeR <= (state == SAC_CONV) && busyMode;
            sdoOutR <= 1'b0; // busy shows low until done
        end else if (cnvFall || (sdoOeR && busyMode && state == SAC_ACQ && outCnt == 5'd0)) begin
            // load last finished result; busy mode prepends one leading bit
            outShift <= busyMode ? {1'b0, result} : {result, 1'b0};
            outCnt <= 5'd0;
            sdoOeR <= 1'b1;
            sdoOutR <= busyMode ? 1'b0 : result[RES_BITS-1];
        end else begin
            if (sckRise && inCnt < 5'(CFG_BITS)) begin
                shiftCfg <= {shiftCfg[CFG_BITS-2:0], dinSync[2]};
                inCnt <= inCnt + 5'd1;
                // full word pends now so this conversion's end hands it on
                if (inCnt == 5'(CFG_BITS - 1)) pendCfg <= {shiftCfg[CFG_BITS-2:0], dinSync[2]};
            end
            if (sckFall && outCnt <= 5'(OUT_BITS + 1)) begin
                outShift <= {outShift[RES_BITS-1:0], 1'b0};
                sdoOutR <= outShift[RES_BITS-1];
                outCnt <= outCnt + 5'd1;
            end
        end
    end

    // outputs straight from flops; power down when not converting and acquisition is done
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowPower <= 1'b1;
            sampling <= 1'b1;
        end else begin
            lowPower <= (state != SAC_CONV) && acqDone;
            sampling <= (state != SAC_CONV);
        end
    end
    assign link.sdoOut = sdoOutR;
    assign link.sdoOe = sdoOeR;
endmodule : sac_device
`default_nettype wire

// file: sac_host.sv
// host end: starts conversions and runs the serial transfer during conversion
`timescale 1ns/10ps
`default_nettype none
module sac_host
    import sac_pkg::*;
#(
    parameter int CYCLE_CYC = 320 // strobe spacing, 2.56 us
)(
    input wire logic clk,                       // system clock
    input wire logic arst_n,                    // async reset, low active
    sac_link_if.host link,                      // serial link
    input wire logic startReq,                  // request one conversion, pulse
    input wire logic [CFG_BITS-1:0] cfgWord,    // config to send
    output logic [RES_BITS-1:0] readData,       // previous result
    output logic readValid                      // one cycle pulse with readData
);
    localparam int HALF = SCK_HALF_CYC;
    logic [8:0] cycCnt;
    logic [4:0] edgeCnt;
    logic [3:0] divCnt;
    logic [8:0] gapCnt;
    logic active, pend, cnvR, sckR, dinR;
    logic [CFG_BITS-1:0] cfgSh;
    logic [RES_BITS-1:0] rxSh;
    wire spaced = (cycCnt == 9'd0);
    wire quietOk = (gapCnt >= 9'(QUIET_CYC));
    wire divEnd = (divCnt == 4'(HALF - 1));

    // strobe pulse then transfer with strobe low, finished well inside 1.0 us
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cycCnt <= 9'd0;
            gapCnt <= 9'd0;
            pend <= 1'b0;
            active <= 1'b0;
            cnvR <= 1'b0;
            sckR <= 1'b0;
            dinR <= 1'b0;
            divCnt <= 4'd0;
            edgeCnt <= 5'd0;
            cfgSh <= '0;
            rxSh <= '0;
            readData <= '0;
            readValid <= 1'b0;
        end else begin
            readValid <= 1'b0;
            if (cycCnt != 9'd0) cycCnt <= cycCnt - 9'd1;
            if (!active && gapCnt != 9'h1FF) gapCnt <= gapCnt + 9'd1;
            if (startReq) pend <= 1'b1;
            if (pend && spaced && quietOk && !active && !cnvR) begin
                cnvR <= 1'b1;
                cycCnt <= 9'(CYCLE_CYC);
                pend <= 1'b0;
                divCnt <= 4'd0;
            end else if (cnvR) begin
                divCnt <= divCnt + 4'd1;
                if (divEnd) begin
                    cnvR <= 1'b0;
                    active <= 1'b1;
                    divCnt <= 4'd0;
                    edgeCnt <= 5'd0;
                    // first config bit set up a half period before the first rise
                    dinR <= cfgWord[CFG_BITS-1];
                    cfgSh <= {cfgWord[CFG_BITS-2:0], 1'b0};
                end
            end else if (active) begin
                // wait one half period after strobe low before first rise
                divCnt <= divEnd ? 4'd0 : divCnt + 4'd1;
                if (divEnd) begin
                    if (!sckR && edgeCnt < 5'(OUT_BITS + 1)) begin
                        sckR <= 1'b1;
                    end else if (sckR) begin
                        // din moves and sdo is taken on the fall, clear of the device's rise
                        sckR <= 1'b0;
                        edgeCnt <= edgeCnt + 5'd1;
                        dinR <= cfgSh[CFG_BITS-1];
                        cfgSh <= {cfgSh[CFG_BITS-2:0], 1'b0};
                        rxSh <= {rxSh[RES_BITS-2:0], link.sdo};
                    end else begin
                        active <= 1'b0;
                        gapCnt <= 9'd0;
                        readData <= rxSh;
                        readValid <= 1'b1;
                    end
                end
            end
        end
    end
    assign link.convertStrobe = cnvR;
    assign link.sck = sckR;
    assign link.din = dinR;
endmodule : sac_host
`default_nettype wire

// file: sac_link_checker.sv
// assertions on the serial link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module sac_link_checker
    import sac_pkg::*;
#(
    parameter int CYCLE_CYC = 320 // host strobe spacing in clocks
)(
    input wire logic clk,           // system clock
    input wire logic arst_n,        // async reset, low active
    input wire logic convertStrobe, // host start / select
    input wire logic sck,           // host serial clock
    input wire logic din,           // config data to device
    input wire logic sdoOut,        // device data
    input wire logic sdoOe,         // device drives data
    input wire logic sdo            // resolved data line
);
    logic prevStrobe;
    logic prevSck;
    logic [15:0] sinceRise;
    logic [15:0] sinceFall;
    logic [4:0] riseCnt;
    // edge decode; sinceRise and sinceFall saturate so a long idle never wraps into a false pass
    wire logic strobeRise = convertStrobe && !prevStrobe;
    wire logic sckFall = !sck && prevSck;
    wire logic sckRise = sck && !prevSck;
    wire logic [15:0] next_sinceRise = strobeRise ? 16'h1 : sinceRise + {15'h0, ~&sinceRise};
    wire logic [15:0] next_sinceFall = sckFall ? 16'h1 : sinceFall + {15'h0, ~&sinceFall};
    wire logic [4:0] next_riseCnt = convertStrobe ? 5'h0 : riseCnt + {4'h0, sckRise};
    // helper state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevStrobe <= 1'b0;
            prevSck <= 1'b0;
            sinceRise <= 16'hFFFF;
            sinceFall <= 16'hFFFF;
            riseCnt <= 5'h0;
        end else begin
            prevStrobe <= convertStrobe;
            prevSck <= sck;
            sinceRise <= next_sinceRise;
            sinceFall <= next_sinceFall;
            riseCnt <= next_riseCnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // clock level held for the minimum half period
    sequence s_clock_low;
        !sck [*2];
    endsequence
    sequence s_clock_high;
        sck [*2];
    endsequence
    property p_data_window;
        $changed(sck) |-> sinceRise <= DATA_CYC;
    endproperty
    property p_quiet_start;
        $rose(convertStrobe) |-> sinceFall >= QUIET_CYC;
    endproperty
    property p_select_setup;
        $fell(convertStrobe) |-> s_clock_low;
    endproperty
    property p_sck_high;
        $rose(sck) |-> s_clock_high;
    endproperty
    property p_sck_low;
        $fell(sck) |-> s_clock_low;
    endproperty
    property p_clock_selected;
        $changed(sck) |-> !convertStrobe;
    endproperty
    property p_edge_count;
        $rose(sck) |-> riseCnt < RES_BITS;
    endproperty
    property p_msb_drive;
        $fell(convertStrobe) |-> ##[0:5] sdoOe;
    endproperty
    property p_spacing;
        $rose(convertStrobe) |-> sinceRise >= CYCLE_CYC;
    endproperty
    a_data_window: assert property (p_data_window) else $error("clocking past data window");
    a_quiet_start: assert property (p_quiet_start) else $error("strobe too soon after sck");
    a_select_setup: assert property (p_select_setup) else $error("sck rose too soon");
    a_sck_high: assert property (p_sck_high) else $error("sck high too short");
    a_sck_low: assert property (p_sck_low) else $error("sck low too short");
    a_clock_selected: assert property (p_clock_selected) else $error("sck moved unselected");
    a_edge_count: assert property (p_edge_count) else $error("too many sck rises");
    a_msb_drive: assert property (p_msb_drive) else $error("data not driven");
    a_spacing: assert property (p_spacing) else $error("strobes too close");
endmodule : sac_link_checker
`default_nettype wire

// file: sac_conversion_tb_top.sv
// bench joining host and device ends over the serial link
`timescale 1ns/10ps
`default_nettype none
module sac_conversion_tb_top
    import sac_pkg::*;
;
    localparam int HOST_CYC = 320;
    // {bipolar, checked, over, under, input code}; a new coding applies one run after it is sent
    localparam logic [21:0] CASES [17] = '{22'h10_0000, 22'h12_0000, 22'h11_FFFF, 22'h13_FFFF,
        22'h10_0001, 22'h18_0005, 22'h14_0005, 22'h20_0000, 22'h30_0000, 22'h32_0000,
        22'h32_0001, 22'h31_FFFF, 22'h30_0000, 22'h33_FFFF, 22'h38_0005, 22'h34_0005,
        22'h20_0000};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic startReq = 1'b0;
    logic [CFG_BITS-1:0] cfgWord = 14'h3FFF;
    logic [RES_BITS-1:0] target = 18'h0_0000;
    logic overRange = 1'b0;
    logic underRange = 1'b0;
    logic prevSck = 1'b0;
    logic [17:0] dinSeen = 18'h0_0000;
    logic [RES_BITS-1:0] prevExp = 18'h0_0000;
    logic prevChk = 1'b0;
    int lowCnt = 0;
    int mismatches = 0;
    int checks = 0;
    wire logic compHigh;
    wire logic lowPower;
    wire logic sampling;
    wire logic readValid;
    wire logic [RES_BITS-1:0] trialCode;
    wire logic [RES_BITS-1:0] readData;
    wire logic [CFG_BITS-1:0] activeCfg;
    always #4 clk = ~clk;
    // comparator stand-in: keep the trial bit while it does not exceed the input
    assign compHigh = (trialCode <= target);
    sac_link_if link();
    sac_device i_sac_device(.clk(clk), .arst_n(arst_n), .link(link), .compHigh(compHigh),
        .overRange(overRange), .underRange(underRange), .lowPower(lowPower),
        .sampling(sampling), .trialCode(trialCode), .activeCfg(activeCfg));
    sac_host #(.CYCLE_CYC(HOST_CYC)) i_sac_host(.clk(clk), .arst_n(arst_n), .link(link),
        .startReq(startReq), .cfgWord(cfgWord), .readData(readData), .readValid(readValid));
    sac_link_checker #(.CYCLE_CYC(HOST_CYC)) i_sac_link_checker(.clk(clk), .arst_n(arst_n),
        .convertStrobe(link.convertStrobe), .sck(link.sck), .din(link.din),
        .sdoOut(link.sdoOut), .sdoOe(link.sdoOe), .sdo(link.sdo));
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task fail(input string msg);
        mismatches++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail
    task check(input logic [17:0] got, input logic [17:0] exp, input string msg);
        checks++;
        if (got !== exp) fail(msg);
    endtask : check
    // code the result should carry, worked out from the coding tables
    function logic [17:0] expCode(input logic [21:0] e);
        if (e[19]) return e[21] ? 18'h1_FFFF : 18'h3_FFFF;
        if (e[18]) return e[21] ? 18'h2_0000 : 18'h0_0000;
        return e[17:0] ^ (e[21] ? 18'h2_0000 : 18'h0_0000);
    endfunction : expCode
    // watch din on sck rises and the length of each conversion; negedge keeps clear of updates
    always @(negedge clk) begin
        prevSck <= link.sck;
        if (link.sck && !prevSck) dinSeen <= {dinSeen[16:0], link.din};
        lowCnt <= sampling ? 0 : lowCnt + 1;
        if (lowCnt == CONV_CYC) fail("conversion overran");
    end
    // one conversion: start it, read back the previous one, then wait for idle
    task run(input logic [21:0] e);
        int n;
        target <= e[17:0];
        overRange <= e[19];
        underRange <= e[18];
        cfgWord <= e[21] ? 14'h2FFF : 14'h3FFF; // bit 12 clear picks bipolar coding
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (readValid !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            fail("no read completed");
            wrap_up();
        end
        if (prevChk) check(readData, prevExp, "result code");
        check({4'h0, dinSeen[17:4]}, {4'h0, cfgWord}, "config bits");
        prevExp = expCode(e);
        prevChk = e[20];
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(sampling === 1'b1 && lowPower === 1'b1) && n < 400);
        if (n >= 400) begin
            fail("no return to idle");
            wrap_up();
        end
        check({16'h0, sampling, lowPower}, 18'h0_0003, "idle state");
        @(posedge clk);
    endtask : run
    // reset, let the first acquisition finish, then walk the table
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (100) @(posedge clk);
        foreach (CASES[i]) run(CASES[i]);
        wrap_up();
    end
endmodule : sac_conversion_tb_top
`default_nettype wire
